// file: logic/nvm_access_map.vh
// register offsets, field positions, reset values and timing for the nvm access block
`ifndef NVM_ACCESS_MAP_VH
`define NVM_ACCESS_MAP_VH

// register offsets on the plain register port
`define NVM_OFS_CONTROL 3'h0
`define NVM_OFS_UNLOCK 3'h1
`define NVM_OFS_DATA 3'h2
`define NVM_OFS_POINTER 3'h3
`define NVM_OFS_FLAGS 3'h4

// nvm_access_control field positions
`define NVM_BIT_READ_START 0
`define NVM_BIT_STORE_START 1
`define NVM_BIT_PERMIT 2
`define NVM_BIT_ABORT 3
`define NVM_BIT_ROW_ERASE 4
`define NVM_BIT_CFG_SEL 6
`define NVM_BIT_FLASH_SEL 7

// peripheral_flag_reg_two field position
`define NVM_BIT_DONE 4

// unlock keys
`define NVM_KEY_FIRST 8'h55
`define NVM_KEY_SECOND 8'haa

// reset value and erased-cell value
`define NVM_BYTE_RST 8'h00
`define NVM_ERASED_BYTE 8'hff

// store array geometry
`define NVM_CELLS 256
`define NVM_AW 8

// self-timed store phases
`define NVM_CLK_MHZ 20
`define NVM_ERASE_TIME_US 2000
`define NVM_PROG_TIME_US 2000
`define NVM_ERASE_CYCLES (`NVM_ERASE_TIME_US * `NVM_CLK_MHZ)
`define NVM_PROG_CYCLES (`NVM_PROG_TIME_US * `NVM_CLK_MHZ)

`endif

// file: logic/nvm_byte_array.v
// byte-wide nonvolatile cell array with one write port and an asynchronous read port
module nvm_byte_array #(
  parameter DEPTH = 256,
  parameter AW = 8
) (
  input wire clk,
  input wire store_permit,
  input wire [AW-1:0] wrAddr,
  input wire [7:0] wrData,
  input wire [AW-1:0] rdAddr,
  output wire [7:0] rdData
);

  // cell storage, deliberately without reset: contents survive any reset
  reg [7:0] cells [0:DEPTH-1];

  // programming port
  always @(posedge clk) begin
    if (store_permit) begin
      cells[wrAddr] <= wrData;
    end
  end

  // combinational read so a read completes in one cycle
  assign rdData = cells[rdAddr];

endmodule

// file: logic/nvm_access_control.v
// register-level controller for indirect access to the on-chip data store
//
// Decided for this implementation: the strobed register port and the register offsets.
`include "nvm_access_map.vh"

// Functional notes
// - 256 byte cells, 8-bit pointer and data
// - store erases cell then programs, self-timed
// - unlock port reads zero, no storage
// - start bits only settable, hardware clears
// - permit gates stores, zero at power-up
// - reset during store sets abort flag
// - aborting reset zeroes pointer and data
// - done flag set, held until software clears
// - bit 7 selects program flash
// - bit 6 selects configuration space
// - row erase on next store, then cleared
// - abort keeps flash select and row erase
// - store-start bit reads one while busy
// - read completes in one cycle
// - read-start refused when flash selected
// - data holds last read until overwritten
// - 55h, AAh, then store-start, per byte
// - permit must precede store-start write
// - permit clear never disturbs running store
module nvm_access_control #(
  parameter ERASE_CYCLES = `NVM_ERASE_CYCLES,
  parameter PROG_CYCLES = `NVM_PROG_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire [2:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output wire [7:0] regRdData,
  input wire extResetPinN,
  input wire timeoutReset,
  output wire storeBusy,
  output wire flashStoreStart,
  output wire cfgStoreStart,
  output wire flashRowErase
);

  // store sequencer states
  localparam ST_IDLE = 2'd0;
  localparam ST_ERASE = 2'd1;
  localparam ST_PROG = 2'd2;

  // unlock tracker states
  localparam UL_NONE = 2'd0;
  localparam UL_FIRST = 2'd1;
  localparam UL_ARMED = 2'd2;

  // software-visible registers
  reg [7:0] cellPointer_r, cellPointer_nxt;
  reg [7:0] byteHolding_r, byteHolding_nxt;
  reg flashSelect_r, flashSelect_nxt;
  reg configSpaceSelect_r, configSpaceSelect_nxt;
  reg rowEraseEnable_r, rowEraseEnable_nxt;
  reg storeAbortFlag_r, storeAbortFlag_nxt;
  reg storePermit_r, storePermit_nxt;
  reg storeStart_r, storeStart_nxt;
  reg readStart_r, readStart_nxt;
  reg storeDoneFlag_r, storeDoneFlag_nxt;
  // internal sequencing
  reg [1:0] unlock_r, unlock_nxt;
  reg [1:0] state_r, state_nxt;
  reg [31:0] timer_r, timer_nxt;
  // store target latched at start, so software may touch registers mid-store
  reg [7:0] storeAddr_r, storeAddr_nxt;
  reg [7:0] storeData_r, storeData_nxt;
  reg storeToArray_r, storeToArray_nxt;
  reg flashStart_r, flashStart_nxt;
  reg cfgStart_r, cfgStart_nxt;
  reg [7:0] rdData_r, rdData_nxt;
  // external reset pin synchroniser
  reg extRstMeta_r, extRstSync_r;
  // array port
  reg arrWrEn;
  reg [7:0] arrWrData;
  wire [7:0] arrRdData;

  // decoded strobes
  wire wrCtrl = regWrite && (regAddr == `NVM_OFS_CONTROL);
  wire wrUnlock = regWrite && (regAddr == `NVM_OFS_UNLOCK);
  wire wrData = regWrite && (regAddr == `NVM_OFS_DATA);
  wire wrPtr = regWrite && (regAddr == `NVM_OFS_POINTER);
  wire wrFlags = regWrite && (regAddr == `NVM_OFS_FLAGS);
  // warm reset: pin is active low and synchronised, supervisor is same-clock
  wire warmReset = ~extRstSync_r | timeoutReset;
  wire busy = (state_r != ST_IDLE);
  wire [31:0] eraseLast = ERASE_CYCLES - 1;
  wire [31:0] progLast = PROG_CYCLES - 1;

  wire storeGo = wrCtrl && regWrWire(regWrData) && (unlock_r == UL_ARMED)
    && storePermit_r && !busy && !warmReset;

  // helper: store-start bit of a control write
  function regWrWire;
    input [7:0] d;
    begin
      regWrWire = d[`NVM_BIT_STORE_START];
    end
  endfunction

  nvm_byte_array #(
    .DEPTH(`NVM_CELLS),
    .AW(`NVM_AW)
  ) u_cells (
    .clk(clk),
    .store_permit(arrWrEn),
    .wrAddr(storeAddr_r),
    .wrData(arrWrData),
    .rdAddr(cellPointer_r),
    .rdData(arrRdData)
  );

  // two-flop synchroniser for the external reset pin; idles high (not in reset)
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      extRstMeta_r <= 1'b1;
      extRstSync_r <= 1'b1;
    end else begin
      extRstMeta_r <= extResetPinN;
      extRstSync_r <= extRstMeta_r;
    end
  end

  // unlock sequence tracker
  always @* begin
    unlock_nxt = unlock_r;
    if (warmReset) begin
      unlock_nxt = UL_NONE;
    end else if (wrUnlock) begin
      if (regWrData == `NVM_KEY_FIRST) begin
        unlock_nxt = UL_FIRST;
      end else if (regWrData == `NVM_KEY_SECOND && unlock_r == UL_FIRST) begin
        unlock_nxt = UL_ARMED;
      end else begin
        unlock_nxt = UL_NONE;
      end
    end else if (regWrite) begin
      // any other write ends the sequence, so every byte needs a fresh unlock
      unlock_nxt = UL_NONE;
    end
  end

  // store sequencer and array write port
  always @* begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    storeAddr_nxt = storeAddr_r;
    storeData_nxt = storeData_r;
    storeToArray_nxt = storeToArray_r;
    arrWrEn = 1'b0;
    arrWrData = `NVM_ERASED_BYTE;
    case (state_r)
      ST_IDLE: begin
        if (storeGo) begin
          // latch target so later register writes cannot corrupt it
          state_nxt = ST_ERASE;
          timer_nxt = 32'h0;
          storeAddr_nxt = cellPointer_r;
          storeData_nxt = byteHolding_r;
          storeToArray_nxt = !flashSelect_r && !configSpaceSelect_r;
        end
      end
      ST_ERASE: begin
        if (timer_r == eraseLast) begin
          arrWrEn = storeToArray_r;
          state_nxt = ST_PROG;
          timer_nxt = 32'h0;
        end else begin
          timer_nxt = timer_r + 32'h1;
        end
      end
      ST_PROG: begin
        if (timer_r == progLast) begin
          arrWrEn = storeToArray_r;
          arrWrData = storeData_r;
          state_nxt = ST_IDLE;
        end else begin
          timer_nxt = timer_r + 32'h1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (warmReset && busy) begin
      state_nxt = ST_IDLE;
      arrWrEn = 1'b0;
    end
  end

  // completion of a store in this cycle
  wire storeEnd = (state_r == ST_PROG) && (timer_r == progLast) && !warmReset;

  // control, data and flag registers
  always @* begin
    cellPointer_nxt = cellPointer_r;
    byteHolding_nxt = byteHolding_r;
    flashSelect_nxt = flashSelect_r;
    configSpaceSelect_nxt = configSpaceSelect_r;
    rowEraseEnable_nxt = rowEraseEnable_r;
    storeAbortFlag_nxt = storeAbortFlag_r;
    storePermit_nxt = storePermit_r;
    storeStart_nxt = storeStart_r;
    readStart_nxt = 1'b0;
    storeDoneFlag_nxt = storeDoneFlag_r;
    flashStart_nxt = 1'b0;
    cfgStart_nxt = 1'b0;
    if (warmReset) begin
      // pointer and data forced to zero
      cellPointer_nxt = `NVM_BYTE_RST;
      byteHolding_nxt = `NVM_BYTE_RST;
      storePermit_nxt = 1'b0;
      storeStart_nxt = 1'b0;
      if (busy) begin
        storeAbortFlag_nxt = 1'b1;
      end
    end else begin
      if (wrPtr) begin
        cellPointer_nxt = regWrData;
      end
      if (wrData) begin
        byteHolding_nxt = regWrData;
      end
      if (wrCtrl) begin
        flashSelect_nxt = regWrData[`NVM_BIT_FLASH_SEL];
        configSpaceSelect_nxt = regWrData[`NVM_BIT_CFG_SEL];
        rowEraseEnable_nxt = regWrData[`NVM_BIT_ROW_ERASE];
        storeAbortFlag_nxt = regWrData[`NVM_BIT_ABORT];
        // permit set by software only, cleared by software or warm reset
        // clearing it leaves a running store alone
        storePermit_nxt = regWrData[`NVM_BIT_PERMIT];
        if (regWrData[`NVM_BIT_READ_START] && !regWrData[`NVM_BIT_FLASH_SEL]) begin
          readStart_nxt = 1'b1;
          // data refreshed only by a read
          byteHolding_nxt = regWrData[`NVM_BIT_CFG_SEL] ? `NVM_BYTE_RST : arrRdData;
        end
      end
      if (storeGo) begin
        storeStart_nxt = 1'b1;
        flashStart_nxt = flashSelect_r && !configSpaceSelect_r;
        cfgStart_nxt = configSpaceSelect_r;
      end
      if (storeEnd) begin
        storeStart_nxt = 1'b0;
        storeAbortFlag_nxt = 1'b0;
        rowEraseEnable_nxt = 1'b0;
      end
      // done flag: set beats software clear
      if (wrFlags) begin
        storeDoneFlag_nxt = regWrData[`NVM_BIT_DONE];
      end
      if (storeEnd) begin
        storeDoneFlag_nxt = 1'b1;
      end
    end
  end

  // read data mux, valid only in the cycle after the read strobe
  always @* begin
    rdData_nxt = 8'h00;
    if (regRead) begin
      case (regAddr)
        `NVM_OFS_CONTROL: begin
          rdData_nxt = {flashSelect_r, configSpaceSelect_r, 1'b0, rowEraseEnable_r,
            storeAbortFlag_r, storePermit_r, storeStart_r, readStart_r};
        end
        `NVM_OFS_UNLOCK: begin
          rdData_nxt = 8'h00;
        end
        `NVM_OFS_DATA: begin
          rdData_nxt = byteHolding_r;
        end
        `NVM_OFS_POINTER: begin
          rdData_nxt = cellPointer_r;
        end
        `NVM_OFS_FLAGS: begin
          rdData_nxt = {3'h0, storeDoneFlag_r, 4'h0};
        end
        // unmapped offsets read as zero
        default: begin
          rdData_nxt = 8'h00;
        end
      endcase
    end
  end

  // state registers except the pin synchroniser; power-up reset clears everything
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cellPointer_r <= `NVM_BYTE_RST;
      byteHolding_r <= `NVM_BYTE_RST;
      flashSelect_r <= 1'b0;
      configSpaceSelect_r <= 1'b0;
      rowEraseEnable_r <= 1'b0;
      storeAbortFlag_r <= 1'b0;
      storePermit_r <= 1'b0;
      storeStart_r <= 1'b0;
      readStart_r <= 1'b0;
      storeDoneFlag_r <= 1'b0;
      unlock_r <= UL_NONE;
      state_r <= ST_IDLE;
      timer_r <= 32'h0;
      storeAddr_r <= 8'h00;
      storeData_r <= 8'h00;
      storeToArray_r <= 1'b0;
      flashStart_r <= 1'b0;
      cfgStart_r <= 1'b0;
      rdData_r <= 8'h00;
    end else begin
      cellPointer_r <= cellPointer_nxt;
      byteHolding_r <= byteHolding_nxt;
      flashSelect_r <= flashSelect_nxt;
      configSpaceSelect_r <= configSpaceSelect_nxt;
      rowEraseEnable_r <= rowEraseEnable_nxt;
      storeAbortFlag_r <= storeAbortFlag_nxt;
      storePermit_r <= storePermit_nxt;
      storeStart_r <= storeStart_nxt;
      readStart_r <= readStart_nxt;
      storeDoneFlag_r <= storeDoneFlag_nxt;
      unlock_r <= unlock_nxt;
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      storeAddr_r <= storeAddr_nxt;
      storeData_r <= storeData_nxt;
      storeToArray_r <= storeToArray_nxt;
      flashStart_r <= flashStart_nxt;
      cfgStart_r <= cfgStart_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  // outputs
  assign regRdData = rdData_r;
  assign storeBusy = storeStart_r;
  // one-cycle requests toward the program flash / configuration writers
  assign flashStoreStart = flashStart_r;
  assign cfgStoreStart = cfgStart_r;
  // row erase qualifier for flash stores
  assign flashRowErase = rowEraseEnable_r;

endmodule

// file: tb/nvm_access_control_chk.sv
// port-level assertion checker for the nvm access controller
`include "nvm_access_map.vh"
module nvm_access_control_chk #(
  parameter ERASE_CYCLES = 4,
  parameter PROG_CYCLES = 4
) (
  input wire clk,
  input wire rst,
  input wire [2:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdData,
  input wire extResetPinN,
  input wire timeoutReset,
  input wire storeBusy,
  input wire flashStoreStart,
  input wire cfgStoreStart,
  input wire flashRowErase
);
  timeunit 1ns;
  timeprecision 100ps;
  // a warm reset may cut a store short, so timing checks stand aside
  wire warm = rst || timeoutReset || !extResetPinN;
  wire wrKey = regWrite && regAddr == `NVM_OFS_UNLOCK;
  reg [15:0] busyCnt_r; // busy cycles so far
  reg key1_r; // first key just written
  reg key2_r; // both keys written in order
  // busy counter and unlock follower; any other write breaks the keys
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busyCnt_r <= 16'h0000;
      key1_r <= 1'b0;
      key2_r <= 1'b0;
    end else begin
      busyCnt_r <= storeBusy ? busyCnt_r + 16'h0001 : 16'h0000;
      if (regWrite) begin
        key1_r <= wrKey && regWrData == `NVM_KEY_FIRST;
        key2_r <= key1_r && wrKey && regWrData == `NVM_KEY_SECOND;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_launch;
    $rose(storeBusy);
  endsequence
  sequence s_oneShot(sig);
    ##1 !sig;
  endsequence
  a_read_idle_zero: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_unlock_reads_zero: assert property (regRead && regAddr == `NVM_OFS_UNLOCK |=> regRdData == 8'h00)
    else $error("unlock port read not zero");
  a_unmapped_zero: assert property (regRead && regAddr > `NVM_OFS_FLAGS |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_start_cause: assert property (s_launch |-> $past(regWrite && regAddr == `NVM_OFS_CONTROL && regWrData[1] && key2_r))
    else $error("store began without key sequence and start write");
  a_busy_length: assert property (disable iff (warm) $fell(storeBusy) |-> busyCnt_r == ERASE_CYCLES + PROG_CYCLES)
    else $error("store length wrong");
  a_flash_pulse: assert property (flashStoreStart |-> s_launch ##0 s_oneShot(flashStoreStart))
    else $error("flash start pulse wrong");
  a_cfg_pulse: assert property (cfgStoreStart |-> s_launch ##0 s_oneShot(cfgStoreStart))
    else $error("config start pulse wrong");
  a_row_erase_clear: assert property (disable iff (warm) $fell(storeBusy) |-> !flashRowErase)
    else $error("row erase not cleared at completion");
  cover property (s_launch);
endmodule

// file: tb/nvm_target_model.sv
// far-side model: program flash and config engines seen through start pulses
module nvm_target_model (
  input wire clk,
  input wire rst,
  input wire flashStoreStart,
  input wire cfgStoreStart,
  input wire flashRowErase,
  output logic [3:0] flashStarts,
  output logic [3:0] cfgStarts,
  output logic [3:0] rowErases
);
  timeunit 1ns;
  timeprecision 100ps;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      flashStarts <= 4'h0;
      cfgStarts <= 4'h0;
      rowErases <= 4'h0;
    end else begin
      if (flashStoreStart) flashStarts <= flashStarts + 4'h1;
      if (cfgStoreStart) cfgStarts <= cfgStarts + 4'h1;
      // erase only counts when asked for at launch
      if (flashStoreStart && flashRowErase) rowErases <= rowErases + 4'h1;
    end
  end
endmodule

// file: tb/data_eeprom_access_control_tb.sv
// self-checking bench for the nvm access controller
`include "nvm_access_map.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module data_eeprom_access_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst, regWrite, regRead, extResetPinN, timeoutReset;
  logic [2:0] regAddr;
  logic [7:0] regWrData, a, d, expv;
  wire [7:0] regRdData;
  wire storeBusy, flashStoreStart, cfgStoreStart, flashRowErase;
  wire [3:0] flashStarts, cfgStarts, rowErases;
  int failures = 0, n_checks = 0, cycles = 0;
  logic [15:0] lfsr_r = 16'hf297; // seed 62103
  logic [7:0] expQ[$]; // pending read answers
  logic rdSeen = 1'b0; // read strobe taken last edge
  logic [7:0] tgt[3] = '{8'h84, 8'h94, 8'h44}; // flash, flash row erase, config
  nvm_access_control #(.ERASE_CYCLES(6), .PROG_CYCLES(6)) u_dut (.clk(clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .extResetPinN(extResetPinN), .timeoutReset(timeoutReset),
    .storeBusy(storeBusy), .flashStoreStart(flashStoreStart), .cfgStoreStart(cfgStoreStart),
    .flashRowErase(flashRowErase));
  nvm_target_model u_model (.clk(clk), .rst(rst), .flashStoreStart(flashStoreStart),
    .cfgStoreStart(cfgStoreStart), .flashRowErase(flashRowErase), .flashStarts(flashStarts),
    .cfgStarts(cfgStarts), .rowErases(rowErases));
  always #25 clk = ~clk;
  function automatic logic [15:0] nextRand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task wr(input logic [2:0] ad, input logic [7:0] dt);
    @(posedge clk);
    regAddr <= ad;
    regWrData <= dt;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  // the answer is noted now and judged by the watcher a cycle later
  task rd(input logic [2:0] ad, input logic [7:0] ex);
    @(posedge clk);
    regAddr <= ad;
    regRead <= 1'b1;
    expQ.push_back(ex);
    @(posedge clk);
    regRead <= 1'b0;
  endtask
  task keys;
    wr(`NVM_OFS_UNLOCK, `NVM_KEY_FIRST);
    wr(`NVM_OFS_UNLOCK, `NVM_KEY_SECOND);
  endtask
  task store(input logic [7:0] ctl);
    wr(`NVM_OFS_CONTROL, ctl);
    keys;
    wr(`NVM_OFS_CONTROL, ctl | 8'h02);
    @(negedge clk);
  endtask
  task waitIdle;
    int k;
    k = 0;
    while (storeBusy !== 1'b0 && k < 40) begin
      @(posedge clk);
      k++;
    end
    `CHK("idle", 1'b0, storeBusy)
  endtask
  task end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watcher: one answer per read strobe, oldest note first
  always @(posedge clk) begin
    if (rdSeen) begin
      expv = expQ.pop_front();
      `CHK("rdata", expv, regRdData)
    end
    rdSeen <= regRead;
  end
  // hang guard well past the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      $display("timeout");
      end_sim;
    end
  end
  initial begin
    {rst, regWrite, regRead, timeoutReset, regAddr, regWrData} = {1'b1, 14'h0000};
    extResetPinN = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
    $display("test reset done");
    lfsr_r = nextRand(lfsr_r);
    {d, a} = lfsr_r;
    wr(`NVM_OFS_POINTER, a);
    wr(`NVM_OFS_DATA, d);
    store(8'h04);
    `CHK("busy", 1'b1, storeBusy)
    wr(`NVM_OFS_CONTROL, 8'h00);
    rd(`NVM_OFS_CONTROL, 8'h02);
    waitIdle;
    rd(`NVM_OFS_CONTROL, 8'h00);
    rd(`NVM_OFS_FLAGS, 8'h10);
    rd(`NVM_OFS_FLAGS, 8'h10);
    wr(`NVM_OFS_FLAGS, 8'h00);
    rd(`NVM_OFS_FLAGS, 8'h00);
    wr(`NVM_OFS_CONTROL, 8'h01);
    rd(`NVM_OFS_DATA, d);
    rd(`NVM_OFS_CONTROL, 8'h00);
    wr(`NVM_OFS_POINTER, a + 8'h01);
    wr(`NVM_OFS_CONTROL, 8'h81);
    rd(`NVM_OFS_DATA, d);
    wr(`NVM_OFS_CONTROL, 8'h41);
    rd(`NVM_OFS_DATA, 8'h00);
    $display("test store done");
    for (int i = 0; i < 3; i++) begin
      wr(`NVM_OFS_CONTROL, i == 1 ? 8'h00 : 8'h04);
      if (i == 0) wr(`NVM_OFS_UNLOCK, `NVM_KEY_SECOND);
      if (i < 2) wr(`NVM_OFS_UNLOCK, `NVM_KEY_FIRST);
      if (i == 1) wr(`NVM_OFS_UNLOCK, `NVM_KEY_SECOND);
      wr(`NVM_OFS_CONTROL, 8'h06);
      @(negedge clk);
      `CHK("refused", 1'b0, storeBusy)
    end
    $display("test refusal done");
    foreach (tgt[i]) begin
      store(tgt[i]);
      `CHK("rowerase", tgt[i][4], flashRowErase)
      waitIdle;
      `CHK("rowclear", 1'b0, flashRowErase)
    end
    `CHK("flash", 4'h2, flashStarts)
    `CHK("cfg", 4'h1, cfgStarts)
    `CHK("erases", 4'h1, rowErases)
    $display("test targets done");
    for (int k = 0; k < 2; k++) begin
      wr(`NVM_OFS_FLAGS, 8'h00);
      wr(`NVM_OFS_POINTER, a);
      store(8'h94);
      @(posedge clk);
      if (k == 0) timeoutReset <= 1'b1;
      else extResetPinN <= 1'b0;
      repeat (5) @(posedge clk);
      timeoutReset <= 1'b0;
      extResetPinN <= 1'b1;
      repeat (4) @(posedge clk);
      rd(`NVM_OFS_CONTROL, 8'h98);
      rd(`NVM_OFS_POINTER, 8'h00);
      rd(`NVM_OFS_DATA, 8'h00);
      rd(`NVM_OFS_FLAGS, 8'h00);
    end
    $display("test abort done");
    repeat (3) @(posedge clk);
    end_sim;
  end
endmodule
bind nvm_access_control nvm_access_control_chk #(.ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES(PROG_CYCLES)) u_chk (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .extResetPinN(extResetPinN), .timeoutReset(timeoutReset), .storeBusy(storeBusy),
  .flashStoreStart(flashStoreStart), .cfgStoreStart(cfgStoreStart),
  .flashRowErase(flashRowErase));
